// ---- verilog/alarm_aggregator.sv ----
`timescale 1ns/100ps
// Functional notes
// - Summary bit 0 is any unmasked flag.
// - Summary drives status pin when routed.
// - Bit 5 sets on active lane FIFO fault.
// - Writing one clears flag, zero keeps it.
// - Bit 4 sets while serializer PLL unlocked.
// - 8B/10B: bit 3 when enabled, not transmitting.
// - 64B/66B: bit 3 on start or realignment.
// - Bit 2 sets when SYSREF realigns clocks.
// - Bit 0 sets on channel divider mismatch.
// - Any reset sets flag register to 3F.
// - Non-divider flags undefined while link disabled.
// - Mask bit one hides its flag.
// - Mask register resets to 3F.
// - Clearing bit 5 clears per-lane faults.
module alarm_aggregator #(
  parameter int LANES = 8,
  parameter int DIV_W = 4
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         soft_reset,
  input  wire logic [alarm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [alarm_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [alarm_pkg::DATA_W-1:0] reg_rdata_q,
  output logic                              reg_rvalid_q,
  input  wire logic [LANES-1:0]             lane_fifo_fault,
  input  wire logic [LANES-1:0]             lane_active,
  input  wire logic                         serializer_pll_locked,
  input  wire logic                         serial_link_enable,
  input  wire logic                         link_mode_64b66b,
  input  wire logic                         data_transmission_state,
  input  wire logic                         link_realign_evt,
  input  wire logic                         sysref_realign_evt,
  input  wire logic [DIV_W-1:0]             div_ab_phase,
  input  wire logic [DIV_W-1:0]             div_cd_phase,
  input  wire logic                         status_pin_route,
  output logic                              status_output_pin_q,
  output logic                              lane_fault_clear_q
);

  // ========================================================================
  // Address decoding.
  // ========================================================================

  // Compares the register port address with one register address.
  function automatic logic addr_is(input logic [alarm_pkg::ADDR_W-1:0] a,
                                   input logic [alarm_pkg::ADDR_W-1:0] target);
    addr_is = (a == target);
  endfunction

  logic hit_summary;
  logic hit_flags;
  logic hit_masks;
  logic wr_flags;
  logic wr_masks;

  // Named strobes for each register.
  assign hit_summary = addr_is(reg_addr, alarm_pkg::ADDR_SUMMARY);
  assign hit_flags   = addr_is(reg_addr, alarm_pkg::ADDR_FLAGS);
  assign hit_masks   = addr_is(reg_addr, alarm_pkg::ADDR_MASKS);
  assign wr_flags    = reg_wr & hit_flags;
  assign wr_masks    = reg_wr & hit_masks;

  // ========================================================================
  // Alarm sources.
  // ========================================================================

  logic                           link_en_prev_q;
  logic                           link_start;
  logic [alarm_pkg::FLAG_W-1:0]   set_vec;
  logic [alarm_pkg::FLAG_W-1:0]   clr_vec;
  logic [alarm_pkg::FLAG_W-1:0]   flags_q;
  logic [alarm_pkg::DATA_W-1:0]   masks_q;
  logic                           summary_d;
  logic                           summary_q;

  // Rising edge of the link enable marks a link start.
  assign link_start = serial_link_enable & ~link_en_prev_q;

  // Set conditions; flags other than bit 3 are not gated by the link enable, so their
  // value while the link is off is simply whatever the sources report.
  assign set_vec[alarm_pkg::BIT_LANE_FIFO] = |(lane_fifo_fault & lane_active);
  assign set_vec[alarm_pkg::BIT_SPLL]      = ~serializer_pll_locked;
  assign set_vec[alarm_pkg::BIT_LINK]      = link_mode_64b66b ?
                                             (link_start | link_realign_evt) :
                                             (serial_link_enable &
                                              ~data_transmission_state);
  assign set_vec[alarm_pkg::BIT_REALIGN]   = sysref_realign_evt;
  assign set_vec[alarm_pkg::BIT_SPARE]     = 1'b0;
  assign set_vec[alarm_pkg::BIT_DIVIDER]   = (div_ab_phase != div_cd_phase);

  // Write-one-to-clear requests.
  assign clr_vec = {alarm_pkg::FLAG_W{wr_flags}} & reg_wdata[alarm_pkg::FLAG_W-1:0];

  // Link enable history for start detection.
  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_reset) begin
      link_en_prev_q <= 1'b0;
    end else begin
      link_en_prev_q <= serial_link_enable;
    end
  end

  // ========================================================================
  // Sticky flags.
  // ========================================================================

  // One sticky cell per flag bit, all resetting to one.
  genvar g;
  generate
    for (g = 0; g < alarm_pkg::FLAG_W; g++) begin : g_flag
      sticky_flag #(
        .RESET_VAL (alarm_pkg::FLAGS_RESET[g])
      ) u_flag (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .soft_reset (soft_reset),
        .set_evt    (set_vec[g]),
        .clear_req  (clr_vec[g]),
        .flag_q     (flags_q[g])
      );
    end
  endgenerate

  // ========================================================================
  // Masks, summary, status pin and per-lane clear.
  // ========================================================================

  // Summary is any flag whose mask bit is clear.
  assign summary_d = |(flags_q & ~masks_q[alarm_pkg::FLAG_W-1:0]);

  // Mask register is plain read/write.
  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_reset) begin
      masks_q <= alarm_pkg::MASKS_RESET;
    end else if (wr_masks) begin
      masks_q <= reg_wdata;
    end
  end

  // Summary, status pin and the one-cycle per-lane clear pulse.
  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_reset) begin
      summary_q           <= 1'b0;
      status_output_pin_q <= 1'b0;
      lane_fault_clear_q  <= 1'b0;
    end else begin
      summary_q           <= summary_d;
      status_output_pin_q <= status_pin_route & summary_d;
      lane_fault_clear_q  <= clr_vec[alarm_pkg::BIT_LANE_FIFO];
    end
  end

  // ========================================================================
  // Register read path.
  // ========================================================================

  logic [alarm_pkg::DATA_W-1:0] rdata_d;

  // Read data selection; unmapped addresses read zero.
  assign rdata_d = hit_summary ? {7'h00, summary_q} :
                   hit_flags   ? {2'h0, flags_q} :
                   hit_masks   ? masks_q : alarm_pkg::READ_ZERO;

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_reset) begin
      reg_rdata_q  <= alarm_pkg::READ_ZERO;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rdata_q  <= reg_rd ? rdata_d : alarm_pkg::READ_ZERO;
      reg_rvalid_q <= reg_rd;
    end
  end

  // ========================================================================
  // Assertions.
  // ========================================================================

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || soft_reset);

  // Summary follows the unmasked flags one cycle later, except just after a reset.
  AST_SUMMARY: assert property (
    $past(rst_n) && !$past(soft_reset)
    |-> summary_q == $past(|(flags_q & ~masks_q[alarm_pkg::FLAG_W-1:0])))
    else $error("Summary bit does not match unmasked flags.");

  // The pin never rises without the summary and its routing.
  AST_PIN: assert property (
    status_output_pin_q |-> summary_q && $past(status_pin_route))
    else $error("Status pin high without routed summary.");

  // Lane FIFO fault sets bit 5.
  AST_FIFO: assert property (
    |(lane_fifo_fault & lane_active) |=> flags_q[alarm_pkg::BIT_LANE_FIFO])
    else $error("Lane FIFO fault flag not set.");

  // Write of one clears a bit whose source is quiet.
  AST_W1C: assert property (
    wr_flags && reg_wdata[alarm_pkg::BIT_SPLL] && serializer_pll_locked
    |=> !flags_q[alarm_pkg::BIT_SPLL])
    else $error("Write of one did not clear the flag.");

  // PLL unlock sets bit 4.
  AST_SPLL: assert property (
    !serializer_pll_locked |=> flags_q[alarm_pkg::BIT_SPLL])
    else $error("PLL unlock flag not set.");

  // 8B/10B link not transmitting sets bit 3.
  AST_LINK8: assert property (
    !link_mode_64b66b && serial_link_enable && !data_transmission_state
    |=> flags_q[alarm_pkg::BIT_LINK])
    else $error("Link flag not set in 8B/10B mode.");

  // 64B/66B link start sets bit 3.
  AST_LINK64: assert property (
    link_mode_64b66b && serial_link_enable && !$past(serial_link_enable)
    |=> flags_q[alarm_pkg::BIT_LINK])
    else $error("Link flag not set on 64B/66B start.");

  // SYSREF realignment sets bit 2.
  AST_REALIGN: assert property (
    sysref_realign_evt |=> flags_q[alarm_pkg::BIT_REALIGN])
    else $error("Realign flag not set.");

  // Divider mismatch sets bit 0.
  AST_DIV: assert property (
    div_ab_phase != div_cd_phase |=> flags_q[alarm_pkg::BIT_DIVIDER])
    else $error("Divider mismatch flag not set.");

  // After any reset both registers read 3F.
  AST_RESET: assert property (@(posedge core_clk) disable iff (1'b0)
    (!rst_n || soft_reset) |=> flags_q == alarm_pkg::FLAGS_RESET
                               && masks_q == alarm_pkg::MASKS_RESET)
    else $error("Reset values wrong.");

  // Fully masked flags never raise the summary.
  AST_MASK: assert property (
    masks_q[alarm_pkg::FLAG_W-1:0] == alarm_pkg::FLAGS_RESET |=> !summary_q)
    else $error("Masked flag reached the summary.");

  // Clearing bit 5 raises the per-lane clear in the next cycle.
  AST_LANECLR: assert property (
    wr_flags && reg_wdata[alarm_pkg::BIT_LANE_FIFO] |=> lane_fault_clear_q)
    else $error("Per-lane clear not pulsed.");

  // A flag without a clear stays set.
  AST_STICKY: assert property (
    flags_q[alarm_pkg::BIT_REALIGN] && !clr_vec[alarm_pkg::BIT_REALIGN]
    |=> flags_q[alarm_pkg::BIT_REALIGN])
    else $error("Flag dropped without a clear.");

  // Main scenarios.
  COV_PIN: cover property (status_pin_route ##1 status_output_pin_q);
  COV_CLEAR_SET: cover property (clr_vec[alarm_pkg::BIT_SPLL] && set_vec[alarm_pkg::BIT_SPLL]);
  COV_READ: cover property (reg_rd && hit_flags ##1 reg_rvalid_q);

endmodule

// ---- shared/alarm_pkg.sv ----
// ==========================================================================
// Shared constants of the alarm aggregator.
// ==========================================================================
package alarm_pkg;

  // Register port widths.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 6;

  // Register addresses on the device register port.
  localparam logic [11:0] ADDR_SUMMARY = 12'h2C0;
  localparam logic [11:0] ADDR_FLAGS   = 12'h2C1;
  localparam logic [11:0] ADDR_MASKS   = 12'h2C2;

  // Reset values.
  localparam logic [5:0] FLAGS_RESET = 6'h3F;
  localparam logic [7:0] MASKS_RESET = 8'h3F;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // Bit positions within the flag and mask registers.
  localparam int BIT_LANE_FIFO = 5;
  localparam int BIT_SPLL      = 4;
  localparam int BIT_LINK      = 3;
  localparam int BIT_REALIGN   = 2;
  localparam int BIT_SPARE     = 1;
  localparam int BIT_DIVIDER   = 0;
  localparam int BIT_SUMMARY   = 0;

endpackage

// ---- verilog/sticky_flag.sv ----
`timescale 1ns/100ps
// ==========================================================================
// One sticky alarm flag, set by hardware and cleared by a write of one.
// ==========================================================================
module sticky_flag #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic soft_reset,
  input  wire logic set_evt,
  input  wire logic clear_req,
  output logic      flag_q
);

  logic flag_d;

  // A set in the same cycle as a clear wins, so no event is lost.
  assign flag_d = set_evt | (flag_q & ~clear_req);

  // Power-on and soft reset both load the reset value.
  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_reset) begin
      flag_q <= RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// ---- tb/tb_alarm_aggregator.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_alarm_aggregator;
  logic        core_clk, rst_n, soft_reset, reg_wr, reg_rd, reg_rvalid_q;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q, lane_fifo_fault, lane_active;
  logic        serializer_pll_locked, serial_link_enable, link_mode_64b66b;
  logic        data_transmission_state, link_realign_evt, sysref_realign_evt;
  logic [3:0]  div_ab_phase, div_cd_phase;
  logic        status_pin_route, status_output_pin_q, lane_fault_clear_q;
  int          bad_count;
  int          compares;
  int          bits [5] = '{5, 4, 3, 2, 0};
  logic [7:0]  m;

  alarm_aggregator #(.LANES(8), .DIV_W(4)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .lane_fifo_fault(lane_fifo_fault),
    .lane_active(lane_active), .serializer_pll_locked(serializer_pll_locked),
    .serial_link_enable(serial_link_enable), .link_mode_64b66b(link_mode_64b66b),
    .data_transmission_state(data_transmission_state),
    .link_realign_evt(link_realign_evt), .sysref_realign_evt(sysref_realign_evt),
    .div_ab_phase(div_ab_phase), .div_cd_phase(div_cd_phase),
    .status_pin_route(status_pin_route), .status_output_pin_q(status_output_pin_q),
    .lane_fault_clear_q(lane_fault_clear_q));

  // ==========================================================================
  // Clock, register port tasks and alarm source control.
  // ==========================================================================
  // The clock toggles every half period of 4 ns.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // One write strobe; the register updates at the edge that samples it.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // One read strobe; the answer stands for one cycle after the sampling edge.
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rvalid_q, 1'b1)
    `CHK(reg_rdata_q, e)
  endtask

  // Raises or drops the fault condition behind one flag bit.
  task automatic src(input int i, input logic on);
    case (i)
      5: lane_fifo_fault <= on ? 8'h01 : 8'h00;
      4: serializer_pll_locked <= !on;
      3: data_transmission_state <= !on;
      2: sysref_realign_evt <= on;
      default: div_cd_phase <= on ? 4'h3 : 4'h0;
    endcase
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the expected run of under two hundred cycles.
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end

  // ==========================================================================
  // Test sequence.
  // ==========================================================================
  // Quiet sources, 8B/10B link running, summary routed to the pin.
  initial begin
    {rst_n, soft_reset, reg_wr, reg_rd, link_mode_64b66b} = 5'h00;
    {link_realign_evt, sysref_realign_evt, reg_addr, reg_wdata} = 22'h0;
    {lane_fifo_fault, div_ab_phase, div_cd_phase} = 16'h0;
    {serializer_pll_locked, serial_link_enable, data_transmission_state} = 3'h7;
    lane_active = 8'h01;
    status_pin_route = 1'b1;
    bad_count = 0;
    compares = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h3F);
    rd_chk(alarm_pkg::ADDR_MASKS, 8'h3F);
    rd_chk(alarm_pkg::ADDR_SUMMARY, 8'h00);
    `CHK(status_output_pin_q, 1'b0)
    wr(alarm_pkg::ADDR_FLAGS, 8'h3F);
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h00);
    $display("reset values done");
    foreach (bits[k]) begin
      m = 8'h01 << bits[k];
      @(posedge core_clk);
      src(bits[k], 1'b1);
      @(posedge core_clk);
      src(bits[k], 1'b0);
      repeat (3) @(posedge core_clk);
      rd_chk(alarm_pkg::ADDR_FLAGS, m);
      rd_chk(alarm_pkg::ADDR_SUMMARY, 8'h00);
      wr(alarm_pkg::ADDR_MASKS, ~m & 8'h3F);
      rd_chk(alarm_pkg::ADDR_SUMMARY, 8'h01);
      `CHK(status_output_pin_q, 1'b1)
      wr(alarm_pkg::ADDR_FLAGS, 8'h00);
      rd_chk(alarm_pkg::ADDR_FLAGS, m);
      wr(alarm_pkg::ADDR_FLAGS, m);
      #1;
      `CHK(lane_fault_clear_q, (bits[k] == 5))
      rd_chk(alarm_pkg::ADDR_FLAGS, 8'h00);
      rd_chk(alarm_pkg::ADDR_SUMMARY, 8'h00);
      wr(alarm_pkg::ADDR_MASKS, 8'h3F);
    end
    $display("flag sources done");
    lane_fifo_fault <= 8'h02;
    serializer_pll_locked <= 1'b0;
    wr(alarm_pkg::ADDR_FLAGS, 8'h10);
    lane_fifo_fault <= 8'h00;
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h10);
    @(posedge core_clk);
    serializer_pll_locked <= 1'b1;
    wr(alarm_pkg::ADDR_FLAGS, 8'h10);
    $display("persistent and idle lane done");
    link_mode_64b66b <= 1'b1;
    serial_link_enable <= 1'b0;
    data_transmission_state <= 1'b0;
    repeat (2) @(posedge core_clk);
    wr(alarm_pkg::ADDR_FLAGS, 8'h3F);
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h00);
    @(posedge core_clk);
    src(0, 1'b1);
    @(posedge core_clk);
    src(0, 1'b0);
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h01);
    wr(alarm_pkg::ADDR_FLAGS, 8'h01);
    @(posedge core_clk);
    serial_link_enable <= 1'b1;
    wr(alarm_pkg::ADDR_FLAGS, 8'h00);
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h08);
    wr(alarm_pkg::ADDR_FLAGS, 8'h08);
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h00);
    @(posedge core_clk);
    link_realign_evt <= 1'b1;
    @(posedge core_clk);
    link_realign_evt <= 1'b0;
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h08);
    $display("64b66b link done");
    wr(alarm_pkg::ADDR_MASKS, 8'hC0);
    rd_chk(alarm_pkg::ADDR_MASKS, 8'hC0);
    wr(alarm_pkg::ADDR_SUMMARY, 8'hFF);
    rd_chk(alarm_pkg::ADDR_SUMMARY, 8'h01);
    rd_chk(12'h2C3, 8'h00);
    `CHK(status_output_pin_q, 1'b1)
    @(posedge core_clk);
    status_pin_route <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(status_output_pin_q, 1'b0)
    @(posedge core_clk);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    rd_chk(alarm_pkg::ADDR_FLAGS, 8'h3F);
    rd_chk(alarm_pkg::ADDR_MASKS, 8'h3F);
    rd_chk(alarm_pkg::ADDR_SUMMARY, 8'h00);
    $display("masks and soft reset done");
    finish_test();
  end
endmodule
